// file: verilog/pwr_rst_pkg.sv
// constants, types and the plain-words summary for the sleep, clock-gate and reset block
// How it works
// - sleep instruction sleeps only when sleep_arm set
// - kind code: idle, noise, power-down, standby
// - power_control bits 2 and 7 read zero
// - clock_gate upper four bits read zero
// - timer1 gate bit freezes and resumes timer1
// - timer0 gate bit freezes and resumes timer0
// - serial gate stops serial clock; software reinitialises
// - converter gate stops converter and comparator clock
// - any reset restores registers; start at vector
// - pins reset asynchronously on level sources; watchdog via its clocked pulse
// - internal reset stretched by delay count after sources
// - four sources: power-on, pin, watchdog, brown-out
// - power-on asserts at once; delay before release
// - long enough low pin resets, even clockless
// - pin rise starts delay, release after timeout
// - enabled brown-out asserts at once; delay on clear
// - watchdog gives one-cycle pulse; its fall starts delay
// - watchdog resets only while enabled
// - enabled watchdog runs in every sleep kind
// - deep sleep disables input buffers except wake pins
// - per-pin disable bits turn off input buffers
// - idle stops cpu and flash clocks only
// - noise sleep stops io, cpu and flash clocks
// - power-down stops oscillator and all clocks
// - standby keeps oscillator when XTAL_SEL set; then wakes in six cycles
package pwr_rst_pkg;
    localparam logic [7:0]  PWR_CTRL_IDX   = 8'h35;
    localparam logic [31:0] PWR_CTRL_ADDR  = {22'h0, PWR_CTRL_IDX, 2'h0};
    localparam logic [31:0] CLK_GATE_ADDR  = 32'h0000_0100;
    localparam logic [31:0] IN_DIS_ADDR    = 32'h0000_0104;
    localparam logic [7:0]  PWR_CTRL_RST   = 8'h00;
    localparam logic [7:0]  PWR_CTRL_WMASK = 8'h7b;
    localparam logic [7:0]  CLK_GATE_RST   = 8'h00;
    localparam logic [7:0]  CLK_GATE_WMASK = 8'h0f;
    localparam logic [15:0] IN_DIS_RST     = 16'h0000;
    localparam int SLEEP_ARM_BIT = 5;
    localparam int KIND_HI_BIT   = 4;
    localparam int KIND_LO_BIT   = 3;
    localparam int G_TIMER1_BIT  = 3;
    localparam int G_TIMER0_BIT  = 2;
    localparam int G_SERIAL_BIT  = 1;
    localparam int G_CONV_BIT    = 0;
    localparam int    CLOCK_MHZ       = 25;
    localparam int    STANDBY_WAKE_CY = 6;
    localparam logic [2:0] STANDBY_WAKE_N = 3'h6;
    localparam int    DELAY_W         = 16;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        KIND_IDLE    = 2'b00,
        KIND_NOISE   = 2'b01,
        KIND_PWRDOWN = 2'b10,
        KIND_STANDBY = 2'b11
    } kind_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE  = 2'b10
    } pstate_t;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic conv;
        logic osc;
        logic timer0;
        logic timer1;
        logic serial;
    } clk_en_t;

    typedef struct packed {
        logic       sel;
        logic       write;
        logic [31:0] addr;
    } ahb_ph_t;

    typedef struct packed {
        logic [7:0]  pwr_ctrl;
        logic [7:0]  clk_gate;
        logic [15:0] in_dis;
        ahb_ph_t     ph;
        pstate_t     st;
        kind_t       kind;
        logic [2:0]  wake_cnt;
        logic [DELAY_W-1:0] dly;
        logic        int_rst;
        logic        wd_pulse;
        logic        wd_hold;
        logic [31:0] rdata;
    } state_t;
endpackage

// file: verilog/pwr_rst_ctrl.sv
// sleep control, peripheral clock gating and reset combining with start-up delay
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pwr_rst_ctrl
(
    // clock and block reset
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // reset sources, active low where named _N
    input  wire logic        POR_N,
    input  wire logic        EXT_RST_N,
    input  wire logic        EXT_RST_EN,
    input  wire logic        BROWNOUT_N,
    input  wire logic        BROWNOUT_EN,
    input  wire logic        WD_EXPIRE,
    input  wire logic        WD_ENABLE,
    input  wire logic [pwr_rst_pkg::DELAY_W-1:0] STARTUP_TIMEOUT,
    // cpu side
    input  wire logic        SLEEP_INSTR,
    input  wire logic        WAKE_REQ,
    input  wire logic        XTAL_SEL,
    input  wire logic [15:0] WAKE_PIN_MASK,
    // outputs
    output logic             INT_RST,
    output logic             PIN_RST,
    output logic             SLEEPING,
    output pwr_rst_pkg::clk_en_t CLK_EN,
    output logic             WD_RUN,
    output logic [15:0]      IN_BUF_EN
);
    pwr_rst_pkg::state_t s_reg;
    pwr_rst_pkg::state_t s_next;
    logic src_n;
    logic any_src;
    logic deep;
    logic wr_ok;
    logic rd_hit;

    // level sources combine asynchronously; watchdog pulse is synchronous
    assign src_n   = POR_N & (EXT_RST_N | ~EXT_RST_EN)
                     & (BROWNOUT_N | ~BROWNOUT_EN);
    assign any_src = ~src_n | s_reg.wd_pulse;
    assign PIN_RST = ~src_n | s_reg.wd_pulse;

    always_comb
    begin
        s_next = s_reg;
        s_next.wd_pulse = 1'b0;
        // watchdog pulse lasts one clock, and only while enabled
        if (WD_EXPIRE && WD_ENABLE && !s_reg.wd_hold)
        begin
            s_next.wd_pulse = 1'b1;
        end
        s_next.wd_hold = WD_EXPIRE & WD_ENABLE;
        // delay counter: reload while a source is active, count down after
        if (any_src)
        begin
            s_next.dly     = STARTUP_TIMEOUT;
            s_next.int_rst = 1'b1;
        end
        else if (s_reg.dly != '0)
        begin
            s_next.dly     = s_reg.dly - 1'b1;
            s_next.int_rst = 1'b1;
        end
        else
        begin
            s_next.int_rst = 1'b0;
        end
        if (s_reg.int_rst)
        begin
            // registers held at initial values during internal reset
            s_next.pwr_ctrl = pwr_rst_pkg::PWR_CTRL_RST;
            s_next.clk_gate = pwr_rst_pkg::CLK_GATE_RST;
            s_next.in_dis   = pwr_rst_pkg::IN_DIS_RST;
            s_next.st       = pwr_rst_pkg::ST_RUN;
            s_next.ph       = '0;
            s_next.rdata    = '0;
        end
        else
        begin
            // data phase of a captured write
            if (s_reg.ph.sel && s_reg.ph.write)
            begin
                unique case (s_reg.ph.addr)
                    pwr_rst_pkg::PWR_CTRL_ADDR:
                        s_next.pwr_ctrl = HWDATA[7:0] & pwr_rst_pkg::PWR_CTRL_WMASK;
                    pwr_rst_pkg::CLK_GATE_ADDR:
                        s_next.clk_gate = HWDATA[7:0] & pwr_rst_pkg::CLK_GATE_WMASK;
                    pwr_rst_pkg::IN_DIS_ADDR:
                        s_next.in_dis = HWDATA[15:0];
                    default:
                        s_next.in_dis = s_reg.in_dis;
                endcase
            end
            s_next.ph.sel   = wr_ok;
            s_next.ph.write = HWRITE;
            s_next.ph.addr  = HADDR;
            s_next.rdata    = '0;
            if (rd_hit)
            begin
                unique case (HADDR)
                    pwr_rst_pkg::PWR_CTRL_ADDR: s_next.rdata = {24'h0, s_reg.pwr_ctrl};
                    pwr_rst_pkg::CLK_GATE_ADDR: s_next.rdata = {24'h0, s_reg.clk_gate};
                    pwr_rst_pkg::IN_DIS_ADDR:   s_next.rdata = {16'h0, s_reg.in_dis};
                    default:                    s_next.rdata = 32'h0;
                endcase
            end
            // sleep sequencing
            unique case (s_reg.st)
                pwr_rst_pkg::ST_RUN:
                    if (SLEEP_INSTR && s_reg.pwr_ctrl[pwr_rst_pkg::SLEEP_ARM_BIT])
                    begin
                        s_next.st   = pwr_rst_pkg::ST_SLEEP;
                        s_next.kind = pwr_rst_pkg::kind_t'(s_reg.pwr_ctrl[
                            pwr_rst_pkg::KIND_HI_BIT:pwr_rst_pkg::KIND_LO_BIT]);
                    end
                pwr_rst_pkg::ST_SLEEP:
                    if (WAKE_REQ)
                    begin
                        if (s_reg.kind == pwr_rst_pkg::KIND_STANDBY && XTAL_SEL)
                        begin
                            s_next.st       = pwr_rst_pkg::ST_WAKE;
                            s_next.wake_cnt = pwr_rst_pkg::STANDBY_WAKE_N - 3'h1;
                        end
                        else
                        begin
                            s_next.st = pwr_rst_pkg::ST_RUN;
                        end
                    end
                pwr_rst_pkg::ST_WAKE:
                    if (s_reg.wake_cnt == 3'h0)
                    begin
                        s_next.st = pwr_rst_pkg::ST_RUN;
                    end
                    else
                    begin
                        s_next.wake_cnt = s_reg.wake_cnt - 3'h1;
                    end
                default:
                    s_next.st = pwr_rst_pkg::ST_RUN;
            endcase
        end
    end

    assign wr_ok  = HSEL & HREADY & (HTRANS == pwr_rst_pkg::HTRANS_NONSEQ) & HWRITE;
    assign rd_hit = HSEL & HREADY & (HTRANS == pwr_rst_pkg::HTRANS_NONSEQ) & ~HWRITE;

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s_reg          <= '0;
            s_reg.int_rst  <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // clock enables per sleep kind and per gate bit
    logic sl;
    logic noio;
    logic noconv;
    assign sl     = (s_reg.st != pwr_rst_pkg::ST_RUN);
    assign noio   = sl & (s_reg.kind != pwr_rst_pkg::KIND_IDLE);
    assign noconv = sl & (s_reg.kind[1]);
    assign deep   = noio & noconv;
    always_comb
    begin
        CLK_EN.cpu    = ~sl;
        CLK_EN.flash  = ~sl;
        CLK_EN.io     = ~noio;
        CLK_EN.conv   = ~noconv & ~s_reg.clk_gate[pwr_rst_pkg::G_CONV_BIT];
        CLK_EN.osc    = ~(sl && s_reg.kind == pwr_rst_pkg::KIND_PWRDOWN)
                        & ~(sl && s_reg.kind == pwr_rst_pkg::KIND_STANDBY
                            && !XTAL_SEL);
        CLK_EN.timer0 = ~noio & ~s_reg.clk_gate[pwr_rst_pkg::G_TIMER0_BIT];
        CLK_EN.timer1 = ~noio & ~s_reg.clk_gate[pwr_rst_pkg::G_TIMER1_BIT];
        CLK_EN.serial = ~noio & ~s_reg.clk_gate[pwr_rst_pkg::G_SERIAL_BIT];
    end

    assign WD_RUN    = WD_ENABLE;
    assign IN_BUF_EN = ~s_reg.in_dis & ({16{~deep}} | WAKE_PIN_MASK);
    assign INT_RST   = s_reg.int_rst;
    assign SLEEPING  = sl;
    assign HRDATA    = s_reg.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // checks
    AST_ARM_GATES: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_reg.st == pwr_rst_pkg::ST_RUN && SLEEP_INSTR && !s_reg.int_rst
         && !s_reg.pwr_ctrl[pwr_rst_pkg::SLEEP_ARM_BIT]) |=> !SLEEPING)
        else $error("slept without arm");
    AST_KIND_CAPT: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_reg.st == pwr_rst_pkg::ST_RUN && $rose(SLEEPING) == 1'b0 && !s_reg.int_rst
         && SLEEP_INSTR && s_reg.pwr_ctrl[pwr_rst_pkg::SLEEP_ARM_BIT])
        |=> s_reg.kind == $past(s_reg.pwr_ctrl[4:3]))
        else $error("wrong sleep kind");
    AST_PC_RSVD: assert property (@(posedge CLOCK) disable iff (!RSTN)
        s_reg.pwr_ctrl[7] == 1'b0 && s_reg.pwr_ctrl[2] == 1'b0)
        else $error("reserved control bit set");
    AST_CG_RSVD: assert property (@(posedge CLOCK) disable iff (!RSTN)
        s_reg.clk_gate[7:4] == 4'h0)
        else $error("reserved gate bit set");
    AST_T1_GATE: assert property (@(posedge CLOCK) disable iff (!RSTN)
        s_reg.clk_gate[3] |-> !CLK_EN.timer1)
        else $error("timer1 clock not gated");
    AST_T0_GATE: assert property (@(posedge CLOCK) disable iff (!RSTN)
        s_reg.clk_gate[2] |-> !CLK_EN.timer0)
        else $error("timer0 clock not gated");
    AST_SER_GATE: assert property (@(posedge CLOCK) disable iff (!RSTN)
        s_reg.clk_gate[pwr_rst_pkg::G_SERIAL_BIT] |-> !CLK_EN.serial)
        else $error("serial clock not gated");
    AST_CONV_GATE: assert property (@(posedge CLOCK) disable iff (!RSTN)
        s_reg.clk_gate[pwr_rst_pkg::G_CONV_BIT] |-> !CLK_EN.conv)
        else $error("converter clock not gated");
    AST_WD_PULSE: assert property (@(posedge CLOCK) disable iff (!RSTN)
        s_reg.wd_pulse |=> !s_reg.wd_pulse)
        else $error("watchdog pulse too long");
    AST_WD_EN: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !WD_ENABLE |=> !s_reg.wd_pulse)
        else $error("watchdog reset while disabled");
    AST_WD_SLEEP: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (SLEEPING && WD_ENABLE) |-> WD_RUN)
        else $error("watchdog stopped in sleep");
    // internal reset must outlast the last source by at least the minimum count
    AST_DELAY: assert property (@(posedge CLOCK) disable iff (!RSTN)
        ($fell(any_src) && STARTUP_TIMEOUT >= 16'h0002)
        |-> INT_RST ##1 INT_RST ##1 INT_RST)
        else $error("reset released before delay");
    AST_REG_INIT: assert property (@(posedge CLOCK) disable iff (!RSTN)
        INT_RST |=> (s_reg.pwr_ctrl == pwr_rst_pkg::PWR_CTRL_RST
                     && s_reg.clk_gate == pwr_rst_pkg::CLK_GATE_RST
                     && s_reg.in_dis == pwr_rst_pkg::IN_DIS_RST))
        else $error("register not initial during reset");
    AST_POR_RST: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !POR_N |-> PIN_RST ##1 INT_RST)
        else $error("power-on reset not immediate");
    AST_EXT_RST: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (!EXT_RST_N && EXT_RST_EN) |-> PIN_RST ##1 INT_RST)
        else $error("pin reset ignored");
    AST_EXT_OFF: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (!EXT_RST_EN && POR_N && (BROWNOUT_N || !BROWNOUT_EN) && !s_reg.wd_pulse)
        |-> !PIN_RST)
        else $error("disabled source caused reset");
    AST_BOD_RST: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (!BROWNOUT_N && BROWNOUT_EN) |-> PIN_RST ##1 INT_RST)
        else $error("brown-out reset ignored");
    AST_IDLE_CLK: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (SLEEPING && s_reg.kind == pwr_rst_pkg::KIND_IDLE)
        |-> (!CLK_EN.cpu && !CLK_EN.flash && CLK_EN.io && CLK_EN.osc))
        else $error("idle clocks wrong");
    AST_NOISE_CLK: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (SLEEPING && s_reg.kind == pwr_rst_pkg::KIND_NOISE)
        |-> (!CLK_EN.io && !CLK_EN.cpu && !CLK_EN.flash && CLK_EN.osc
             && CLK_EN.conv == !s_reg.clk_gate[pwr_rst_pkg::G_CONV_BIT]))
        else $error("noise sleep clocks wrong");
    AST_PWRDN_CLK: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (SLEEPING && s_reg.kind == pwr_rst_pkg::KIND_PWRDOWN) |-> CLK_EN == '0)
        else $error("clock running in power-down");
    AST_STBY_OSC: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (SLEEPING && s_reg.kind == pwr_rst_pkg::KIND_STANDBY && XTAL_SEL)
        |-> (CLK_EN.osc && !CLK_EN.io))
        else $error("standby oscillator wrong");
    // six cycles in the wake state: sampled high six times, low on the seventh
    AST_STBY_WAKE: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_reg.st == pwr_rst_pkg::ST_WAKE && !s_reg.int_rst
         && s_reg.wake_cnt == pwr_rst_pkg::STANDBY_WAKE_N - 3'h1)
        |-> SLEEPING [*6] ##1 (!SLEEPING || s_reg.int_rst))
        else $error("standby wake not six cycles");
    AST_DEEP_BUF: assert property (@(posedge CLOCK) disable iff (!RSTN)
        deep |-> ((IN_BUF_EN & ~WAKE_PIN_MASK) == 16'h0))
        else $error("input buffer on in deep sleep");
    AST_IN_DIS: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (IN_BUF_EN & s_reg.in_dis) == 16'h0)
        else $error("disabled input buffer on");
    COV_SLEEP: cover property (@(posedge CLOCK) disable iff (!RSTN) $rose(SLEEPING));
    COV_WD: cover property (@(posedge CLOCK) disable iff (!RSTN) s_reg.wd_pulse);
    COV_STBY: cover property (@(posedge CLOCK) disable iff (!RSTN)
        s_reg.st == pwr_rst_pkg::ST_WAKE);
    COV_REL: cover property (@(posedge CLOCK) disable iff (!RSTN) $fell(INT_RST));
    COV_DEEP: cover property (@(posedge CLOCK) disable iff (!RSTN) deep);
endmodule
`default_nettype wire

// file: tb/cpu_core_model.sv
// processor core model: ahb-lite master and sleep instruction
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
(
    // clock
    input  wire logic        clock,
    // ahb-lite master
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var logic         hsel = 1'b0,
    output var logic [31:0]  haddr = 32'h0,
    output var logic [1:0]   htrans = 2'h0,
    output var logic         hwrite = 1'b0,
    output var logic [2:0]   hsize = 3'h2,
    output var logic [31:0]  hwdata = 32'h0,
    // sleep instruction and read results
    output var logic         sleep_instr = 1'b0,
    output var logic         rvalid = 1'b0,
    output var logic [31:0]  rdata = 32'h0
);
    logic rd_ph = 1'b0;

    // read data is taken at the edge that ends the data phase
    always @(posedge clock)
    begin
        rvalid <= rd_ph;
        rdata  <= hrdata;
    end

    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (hready !== 1'b1 && n < 100);
    endtask

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel   <= 1'b1;
        htrans <= pwr_rst_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= a;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        haddr  <= ~a;
        hwdata <= d;
        rd_ph  <= !wr;
        wait_rdy();
        rd_ph  <= 1'b0;
        hwdata <= ~d;
    endtask

    task automatic sleep_op();
        @(posedge clock);
        sleep_instr <= 1'b1;
        @(posedge clock);
        sleep_instr <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/pwr_rst_ctrl_bench.sv
// self-checking bench for the sleep, clock-gate and reset block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value t=%0t got %0h exp %0h", $time, a, b); end end
module pwr_rst_ctrl_bench;
    logic [15:0] tmo = 16'h0005;
    localparam logic [31:0] pa = pwr_rst_pkg::PWR_CTRL_ADDR;
    localparam logic [31:0] ga = pwr_rst_pkg::CLK_GATE_ADDR;
    localparam logic [31:0] da = pwr_rst_pkg::IN_DIS_ADDR;
    logic clock, rstn = 1'b0, wd_expire = 1'b0, wd_enable = 1'b1, wake_req = 1'b0;
    logic ext_rst_en = 1'b1, brownout_en = 1'b1, xtal_sel = 1'b0;
    logic [2:0]  low_n = 3'h6;
    logic [15:0] mask = 16'h0, dis = 16'h0;
    logic [31:0] seed = 32'h0000_b7a0, hrdata, haddr, hwdata, rdata, exp_rd;
    logic [31:0] exp_q[$];
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic hsel, hwrite, hready, rvalid, sleep_instr, int_rst, pin_rst, sleeping, wd_run;
    logic [15:0] in_buf_en;
    logic [3:0]  per_en;
    logic        hresp;
    pwr_rst_pkg::clk_en_t clk_en;
    int fail_count = 0, num_checks = 0, cycles = 0;

    pwr_rst_ctrl dut (.CLOCK(clock), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .POR_N(low_n[0]), .EXT_RST_N(low_n[1]), .EXT_RST_EN(ext_rst_en),
        .BROWNOUT_N(low_n[2]), .BROWNOUT_EN(brownout_en), .WD_EXPIRE(wd_expire),
        .WD_ENABLE(wd_enable), .STARTUP_TIMEOUT(tmo), .SLEEP_INSTR(sleep_instr),
        .WAKE_REQ(wake_req), .XTAL_SEL(xtal_sel), .WAKE_PIN_MASK(mask),
        .INT_RST(int_rst), .PIN_RST(pin_rst), .SLEEPING(sleeping), .CLK_EN(clk_en),
        .WD_RUN(wd_run), .IN_BUF_EN(in_buf_en));
    cpu_core_model cpu (.clock(clock), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .sleep_instr(sleep_instr), .rvalid(rvalid), .rdata(rdata));
    assign per_en = {clk_en.timer1, clk_en.timer0, clk_en.serial, clk_en.conv};

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        cpu.xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        cpu.xfer(1'b0, a, 32'h0);
    endtask

    // counts edges until the given flag drops
    task automatic edges_until_low(input bit use_sleep, output int n);
        n = 0;
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end
        while ((use_sleep ? sleeping : int_rst) !== 1'b0 && n < 50);
    endtask

    task automatic src_test(input int s, input logic en);
        int n;
        logic act;
        act = (s == 0) || en;
        wr(ga, 32'hf);
        @(posedge clock);
        ext_rst_en <= en;
        brownout_en <= en;
        low_n <= ~(3'h1 << s);
        #1;
        `CHK(pin_rst, act)
        repeat (3) @(posedge clock);
        #1;
        `CHK(int_rst, act)
        @(posedge clock);
        low_n <= 3'h7;
        edges_until_low(1'b0, n);
        `CHK(n, act ? int'(tmo) + 1 : 1)
        rd(ga, act ? 32'h0 : 32'hf);
    endtask

    task automatic wd_test(input logic en);
        int n;
        @(posedge clock);
        wd_enable <= en;
        wd_expire <= 1'b1;
        @(posedge clock);
        #1;
        `CHK(pin_rst, en)
        `CHK(wd_run, en)
        @(posedge clock);
        wd_expire <= 1'b0;
        #1;
        `CHK(pin_rst, 1'b0)
        `CHK(int_rst, en)
        edges_until_low(1'b0, n);
        `CHK(n, en ? int'(tmo) + 1 : 1)
    endtask

    task automatic sleep_test(input logic [1:0] k, input logic x);
        int n;
        logic [4:0] e;
        e = (k == 2'h0) ? 5'h07 : (k == 2'h1) ? 5'h03 : (k == 2'h3 && x) ? 5'h01 : 5'h00;
        @(posedge clock);
        mask <= 16'(rnd());
        xtal_sel <= x;
        wr(pa, {26'h0, 1'b1, k, 3'h0});
        cpu.sleep_op();
        #1;
        `CHK(sleeping, 1'b1)
        `CHK({clk_en.cpu, clk_en.flash, clk_en.io, clk_en.conv, clk_en.osc}, e)
        `CHK(in_buf_en, k[1] ? (mask & ~dis) : ~dis)
        `CHK(wd_run, wd_enable)
        @(posedge clock);
        wake_req <= 1'b1;
        edges_until_low(1'b1, n);
        `CHK(n, (k == 2'h3 && x) ? 7 : 1)
        @(posedge clock);
        wake_req <= 1'b0;
        wr(pa, 32'h0);
    endtask

    // the note is taken off once, so a mismatch cannot swallow a second one
    always @(negedge clock)
    begin
        if (rvalid === 1'b1 && exp_q.size() > 0)
        begin
            exp_rd = exp_q.pop_front();
            `CHK(rdata, exp_rd)
        end
        if (hsel === 1'b1)
            `CHK(hresp, 1'b0)
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            finish_test();
        end
    end

    initial
    begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        src_test(0, 1'b1);
        rd(pa, 32'h0);
        rd(da, 32'h0);
        wr(pa, 32'hff);
        rd(pa, 32'h7b);
        wr(ga, 32'hff);
        rd(ga, 32'hf);
        wr(32'h200, 32'hff);
        rd(32'h200, 32'h0);
        dis = 16'(rnd());
        wr(da, {16'h0, dis});
        rd(da, {16'h0, dis});
        #1;
        `CHK(in_buf_en, ~dis)
        // each gate bit set alone: its own clock off, the other three clocks on
        for (int i = 0; i < 4; i++)
        begin
            wr(ga, 32'h1 << i);
            #1;
            `CHK(per_en, ~(4'h1 << i))
            rd(ga, 32'h1 << i);
        end
        wr(ga, 32'h0);
        wr(pa, 32'h10);
        cpu.sleep_op();
        #1;
        `CHK(sleeping, 1'b0)
        for (int k = 0; k < 4; k++)
            sleep_test(2'(k), 1'b0);
        sleep_test(2'h3, 1'b1);
        for (int s = 0; s < 3; s++)
            for (int en = 0; en < 2; en++)
                src_test(s, 1'(en));
        @(posedge clock);
        tmo <= 16'h0002 + 16'(rnd() & 32'h3);
        wd_test(1'b1);
        wd_test(1'b0);
        repeat (3) @(posedge clock);
        finish_test();
    end
endmodule
`default_nettype wire
